// ===== hw/fpi_image_mux.v
`timescale 1ns/1ps
`include "fpi_map.vh"
module fpi_image_mux
#(
  parameter NBLK = 12
)
(
  input  wire [7:0]          byte_idx,
  input  wire [15:0]         err_word,
  input  wire [15:0]         stat_word,
  input  wire [7:0]          ack_byte,
  input  wire [7:0]          cerr_byte,
  input  wire [15:0]         rd_addr,
  input  wire [12*16-1:0]    rd_data,
  input  wire [NBLK*128-1:0] blk_data,
  input  wire [3:0]          blk_count,
  output reg  [7:0]          byte_val
);
  function [7:0] hi_lo;
    input [15:0] w;
    input        lo;
    hi_lo = lo ? w[7:0] : w[15:8];
  endfunction

  reg [7:0] rel;
  reg [3:0] blk;
  reg [3:0] reg_n;
  always @*
  begin
    rel      = 8'h00;
    blk      = 4'h0;
    reg_n    = 4'h0;
    byte_val = 8'h00;
    if (byte_idx < 8'd2)
      byte_val = hi_lo(err_word, byte_idx[0]);
    else if (byte_idx < 8'd4)
      byte_val = hi_lo(stat_word, byte_idx[0]);
    else if (byte_idx == 8'd4)
      byte_val = ack_byte;
    else if (byte_idx == 8'd5)
      byte_val = cerr_byte;
    else if (byte_idx < 8'd8)
      byte_val = hi_lo(rd_addr, byte_idx[0]);
    else if (byte_idx < `FPI_IN_BASE_BYTES)
    begin
      rel      = byte_idx - 8'd8;
      reg_n    = rel[4:1];
      byte_val = hi_lo(rd_data[reg_n*16 +: 16], rel[0]);
    end
    else if (byte_idx < `FPI_IN_MAX_BYTES)
    begin
      rel = byte_idx - 8'd32;
      blk = rel[7:4];
      if (blk < blk_count)
        byte_val = blk_data[blk*128 + (15 - rel[3:0])*8 +: 8];
    end
  end
endmodule // fpi_image_mux

// ===== hw/fpi_process_image.v
`timescale 1ns/1ps
`include "fpi_map.vh"
// Summary of operation
// - Output block always 16 bytes, mapped
// - Command, count, address, six write words
// - Execute only on changed command byte
// - Input base block of 32 bytes
// - Error word in bytes 0-1, zero ok
// - Ack equals command, or 240 on fail
// - Command error byte, zero on success
// - Bytes 6-7 give read window start
// - Twelve read registers refreshed continuously
// - Data blocks at byte 32 plus 16n
// - Image ends at byte 223
// - Unused block content reads as zero
// - Restart after fieldbus type change
// - Block count zero to twelve
module fpi_process_image
#(
  parameter NBLK = 12
)
(
  input  wire                clk,
  input  wire                reset_n,
  input  wire [8*16-1:0]     out_block,
  input  wire [15:0]         inst_error,
  input  wire [15:0]         inst_status_in,
  input  wire [3:0]          blk_count_cfg,
  input  wire [NBLK*128-1:0] blk_data,
  input  wire [1:0]          bus_type_cfg,
  input  wire [7:0]          in_byte_idx,
  input  wire [15:0]         reg_rd_data,
  input  wire                ext_cmd_ok,
  input  wire                ext_cmd_done,
  input  wire [7:0]          ext_cmd_err,
  output reg  [7:0]          in_byte_q,
  output reg  [15:0]         reg_rd_addr_q,
  output reg                 reg_wr_en_q,
  output reg  [15:0]         reg_wr_addr_q,
  output reg  [15:0]         reg_wr_data_q,
  output reg                 ext_cmd_go_q,
  output reg  [7:0]          ext_cmd_q,
  output reg                 restart_q,
  output reg  [7:0]          ack_q,
  output reg  [7:0]          cerr_q,
  output reg  [15:0]         rd_start_q
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WR   = 2'd1;
  localparam ST_EXT  = 2'd2;

  function [15:0] out_word;
    input [8*16-1:0] blkv;
    input [3:0]      n;
    out_word = {blkv[(15 - n)*8 +: 8], blkv[(14 - n)*8 +: 8]};
  endfunction

  wire [7:0]  cmd_byte  = out_block[127:120];
  wire [7:0]  wr_count  = out_block[119:112];
  wire [15:0] start_adr = out_word(out_block, 4'd2);

  reg  [7:0]  cmd_prev_q;
  reg  [1:0]  state_q;
  reg  [2:0]  wr_idx_q;
  reg  [2:0]  wr_num_q;
  reg  [7:0]  cur_cmd_q;
  reg  [15:0] wr_base_q;
  reg  [3:0]  rd_idx_q;
  reg  [3:0]  rd_idx_d1_q;
  reg         rd_vld_q;
  reg  [15:0] rd_regs_q [0:11];
  reg  [12*16-1:0] rd_flat;
  reg  [1:0]  bus_type_q;
  reg         bus_seen_q;
  reg         prst_clr_q;
  wire [3:0]  blk_count = (blk_count_cfg > 4'd12) ? 4'd12 : blk_count_cfg;
  wire [7:0]  mux_byte;
  integer     i;
  integer     j;

  always @*
  begin
    rd_flat = {12*16{1'b0}};
    for (i = 0; i < 12; i = i + 1)
      rd_flat[i*16 +: 16] = rd_regs_q[i];
  end

  fpi_image_mux #(.NBLK(NBLK)) u_mux
  (
    .byte_idx  (in_byte_idx),
    .err_word  (inst_error),
    .stat_word (prst_clr_q ? (inst_status_in & ~`FPI_STATUS_RESET) : inst_status_in),
    .ack_byte  (ack_q),
    .cerr_byte (cerr_q),
    .rd_addr   (rd_start_q),
    .rd_data   (rd_flat),
    .blk_data  (blk_data),
    .blk_count (blk_count),
    .byte_val  (mux_byte)
  );

  // Round-robin refresh of the read window
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_idx_q      <= 4'h0;
      rd_idx_d1_q   <= 4'h0;
      rd_vld_q      <= 1'b0;
      reg_rd_addr_q <= `FPI_RDADDR_RESET;
      in_byte_q     <= 8'h00;
      for (j = 0; j < 12; j = j + 1)
        rd_regs_q[j] <= 16'h0000;
    end
    else
    begin
      in_byte_q     <= mux_byte;
      rd_idx_q      <= (rd_idx_q == 4'd11) ? 4'h0 : rd_idx_q + 4'h1;
      reg_rd_addr_q <= rd_start_q + {12'h000, rd_idx_q};
      rd_idx_d1_q   <= rd_idx_q;
      rd_vld_q      <= 1'b1;
      if (rd_vld_q)
        rd_regs_q[rd_idx_d1_q] <= reg_rd_data;
    end
  end

  // Restart pulse on change of fieldbus type
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_type_q <= 2'b00;
      bus_seen_q <= 1'b0;
      restart_q  <= 1'b0;
    end
    else
    begin
      bus_type_q <= bus_type_cfg;
      bus_seen_q <= 1'b1;
      restart_q  <= bus_seen_q && (bus_type_q != bus_type_cfg);
    end
  end

  // Command interpreter
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_prev_q    <= `FPI_CMD_NONE;
      state_q       <= ST_IDLE;
      wr_idx_q      <= 3'd0;
      wr_num_q      <= 3'd0;
      cur_cmd_q     <= `FPI_CMD_NONE;
      wr_base_q     <= 16'h0000;
      reg_wr_en_q   <= 1'b0;
      reg_wr_addr_q <= 16'h0000;
      reg_wr_data_q <= 16'h0000;
      ext_cmd_go_q  <= 1'b0;
      ext_cmd_q     <= 8'h00;
      ack_q         <= `FPI_CMD_NONE;
      cerr_q        <= `FPI_CERR_NONE;
      rd_start_q    <= `FPI_RDADDR_RESET;
      prst_clr_q    <= 1'b0;
    end
    else
    begin
      reg_wr_en_q  <= 1'b0;
      ext_cmd_go_q <= 1'b0;
      if (restart_q)
        prst_clr_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (cmd_byte != cmd_prev_q)
          begin
            cmd_prev_q <= cmd_byte;
            cur_cmd_q  <= cmd_byte;
            case (cmd_byte)
              `FPI_CMD_NONE:
              begin
              end
              `FPI_CMD_WINDOW:
              begin
                rd_start_q <= start_adr;
                ack_q      <= cmd_byte;
                cerr_q     <= `FPI_CERR_NONE;
              end
              `FPI_CMD_WRITE:
              begin
                if (wr_count == 8'd0 || wr_count > `FPI_WR_REGS_MAX)
                begin
                  ack_q  <= `FPI_ACK_FAIL;
                  cerr_q <= `FPI_CERR_COUNT;
                end
                else
                begin
                  wr_num_q  <= wr_count[2:0];
                  wr_idx_q  <= 3'd0;
                  wr_base_q <= start_adr;
                  state_q   <= ST_WR;
                end
              end
              `FPI_CMD_CLR_PRST:
              begin
                prst_clr_q <= 1'b1;
                ack_q      <= cmd_byte;
                cerr_q     <= `FPI_CERR_NONE;
              end
              default:
              begin
                ext_cmd_q    <= cmd_byte;
                ext_cmd_go_q <= 1'b1;
                state_q      <= ST_EXT;
              end
            endcase
          end
        end
        ST_WR:
        begin
          reg_wr_en_q   <= 1'b1;
          reg_wr_addr_q <= wr_base_q + {13'h0000, wr_idx_q};
          reg_wr_data_q <= out_word(out_block, {wr_idx_q, 1'b0} + 4'd4);
          wr_idx_q      <= wr_idx_q + 3'd1;
          if (wr_idx_q + 3'd1 == wr_num_q)
          begin
            ack_q   <= cur_cmd_q;
            cerr_q  <= `FPI_CERR_NONE;
            state_q <= ST_IDLE;
          end
        end
        ST_EXT:
        begin
          if (ext_cmd_done)
          begin
            ack_q   <= ext_cmd_ok ? cur_cmd_q : `FPI_ACK_FAIL;
            cerr_q  <= ext_cmd_ok ? `FPI_CERR_NONE : ext_cmd_err;
            state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // fpi_process_image

// ===== inc/fpi_map.vh
`ifndef FPI_MAP_VH
`define FPI_MAP_VH
`define FPI_OUT_BYTES     16
`define FPI_IN_BASE_BYTES 32
`define FPI_IN_MAX_BYTES  224
`define FPI_BLK_BYTES     16
`define FPI_BLK_MAX       12
`define FPI_RD_REGS       12
`define FPI_WR_REGS_MAX   6
`define FPI_CMD_NONE      8'h00
`define FPI_CMD_WINDOW    8'hfa
`define FPI_CMD_WRITE     8'hfb
`define FPI_CMD_CLR_PRST  8'hfc
`define FPI_ACK_FAIL      8'hf0
`define FPI_CERR_NONE     8'h00
`define FPI_CERR_COUNT    8'h01
`define FPI_CERR_UNKNOWN  8'h02
`define FPI_CERR_REJECT   8'h03
`define FPI_PRST_BIT      0
`define FPI_STATUS_RESET  16'h0001
`define FPI_RDADDR_RESET  16'h0000
`endif

// ===== test/fpi_monitor.sv
`timescale 1ns/1ps
module fpi_monitor
(
  input wire        clk,
  input wire        reset_n,
  input wire [7:0]  in_byte_idx,
  input wire [7:0]  in_byte_q,
  input wire        reg_wr_en_q,
  input wire [15:0] reg_wr_addr_q,
  input wire [15:0] reg_rd_addr_q,
  input wire [1:0]  bus_type_cfg,
  input wire        restart_q,
  input wire [7:0]  ack_q,
  input wire [7:0]  cerr_q,
  input wire [15:0] rd_start_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_fail_has_code:
    assert property ($changed(ack_q) && ack_q == 8'hf0 |-> cerr_q != 8'h00)
    else $error("fail ack without code");
  a_ok_zero_code:
    assert property ($changed(ack_q) && ack_q != 8'hf0 |-> cerr_q == 8'h00)
    else $error("ok ack with code");
  a_wr_addr_step:
    assert property (reg_wr_en_q && $past(reg_wr_en_q)
      |-> reg_wr_addr_q == $past(reg_wr_addr_q) + 16'h0001)
    else $error("write address not consecutive");
  a_wr_max_six:
    assert property (reg_wr_en_q [*6] |=> !reg_wr_en_q)
    else $error("more than six writes");
  a_wr_end_ack:
    assert property ($fell(reg_wr_en_q) |-> ack_q == 8'hfb)
    else $error("write burst without ack");
  a_rd_in_window:
    assert property ($stable(rd_start_q) [*3] |-> reg_rd_addr_q - rd_start_q < 16'h000c)
    else $error("read address outside window");
  a_start_byte:
    assert property (in_byte_idx == 8'h07 |=> in_byte_q == $past(rd_start_q[7:0]))
    else $error("byte 7 wrong");
  a_ack_byte:
    assert property (in_byte_idx == 8'h04 |=> in_byte_q == $past(ack_q))
    else $error("byte 4 wrong");
  a_end_zero:
    assert property (in_byte_idx >= 8'he0 |=> in_byte_q == 8'h00)
    else $error("byte past end not zero");
  a_restart_pulse:
    assert property ($changed(bus_type_cfg) |-> ##[1:2] restart_q)
    else $error("no restart on type change");
endmodule // fpi_monitor
bind fpi_process_image fpi_monitor u_mon
(
  .clk, .reset_n, .in_byte_idx, .in_byte_q, .reg_wr_en_q, .reg_wr_addr_q,
  .reg_rd_addr_q, .bus_type_cfg, .restart_q, .ack_q, .cerr_q, .rd_start_q
);

// ===== test/fpi_reg_model.sv
`timescale 1ns/1ps
module fpi_reg_model
(
  input  wire        clk,
  input  wire        reset_n,
  input  wire [15:0] reg_rd_addr,
  input  wire        go,
  input  wire [7:0]  cmd,
  output wire [15:0] rd_data,
  output wire        done,
  output wire        ok,
  output wire [7:0]  err
);
  reg [2:0] dly_q;
  // Register value derived from address
  assign rd_data = {reg_rd_addr[7:0], ~reg_rd_addr[7:0]};
  // Odd command codes are refused
  assign ok = ~cmd[0];
  assign err = ok ? 8'h00 : 8'h07;
  assign done = dly_q[2];
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      dly_q <= 3'h0;
    else
      dly_q <= {dly_q[1:0], go};
endmodule // fpi_reg_model

// ===== test/tb_fieldbus_process_image.sv
`timescale 1ns/1ps
module tb_fieldbus_process_image;
  reg           clk = 0;
  reg           reset_n = 0;
  reg  [127:0]  out_block = 0;
  reg  [15:0]   inst_error = 16'h0000;
  reg  [15:0]   inst_status_in = 16'h0001;
  reg  [3:0]    blk_count_cfg = 4'h2;
  reg  [1535:0] blk_data = 0;
  reg  [1:0]    bus_type_cfg = 2'h0;
  reg  [7:0]    in_byte_idx = 0;
  reg  [7:0]    k;
  reg  [127:0]  ob;
  reg  [15:0]   wa, wd;
  wire [15:0]   reg_rd_data, reg_rd_addr_q, reg_wr_addr_q, reg_wr_data_q, rd_start_q;
  wire          ext_cmd_ok, ext_cmd_done, reg_wr_en_q, ext_cmd_go_q, restart_q;
  wire [7:0]    ext_cmd_err, in_byte_q, ext_cmd_q, ack_q, cerr_q;
  integer       n_fail = 0, checks = 0, cyc = 0, n_wr = 0, n_rs = 0;
  fpi_process_image dut
  (
    .clk, .reset_n, .out_block, .inst_error, .inst_status_in, .blk_count_cfg, .blk_data,
    .bus_type_cfg, .in_byte_idx, .reg_rd_data, .ext_cmd_ok, .ext_cmd_done, .ext_cmd_err,
    .in_byte_q, .reg_rd_addr_q, .reg_wr_en_q, .reg_wr_addr_q, .reg_wr_data_q,
    .ext_cmd_go_q, .ext_cmd_q, .restart_q, .ack_q, .cerr_q, .rd_start_q
  );
  fpi_reg_model u_far
  (
    .clk, .reset_n, .reg_rd_addr(reg_rd_addr_q), .go(ext_cmd_go_q), .cmd(ext_cmd_q),
    .rd_data(reg_rd_data), .done(ext_cmd_done), .ok(ext_cmd_ok), .err(ext_cmd_err)
  );
  always #50 clk = ~clk;
  task wrap_up;
    begin
      $display("checks %0d fails %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [7:0] g, input [7:0] e);
    begin
      checks = checks + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rd(input [7:0] i, input [7:0] e);
    begin
      @(negedge clk);
      in_byte_idx = i;
      @(negedge clk);
      chk("byte", in_byte_q, e);
    end
  endtask
  task cmd(input [127:0] b);
    begin
      @(negedge clk);
      out_block = b;
      repeat (24) @(negedge clk);
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (reg_wr_en_q === 1'b1)
    begin
      n_wr <= n_wr + 1;
      wa <= reg_wr_addr_q;
      wd <= reg_wr_data_q;
    end
    if (restart_q === 1'b1)
      n_rs <= n_rs + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  initial
  begin
    blk_data[255:248] = 8'h31;
    blk_data[1535:1528] = 8'hbc;
    repeat (20) @(negedge clk);
    reset_n = 1;
    rd(8'h03, 8'h01);
    inst_error = 16'h1234;
    rd(8'h00, 8'h12);
    rd(8'h01, 8'h34);
    $display("test base done");
    cmd({8'hfa, 8'h00, 16'h0010, 96'h0});
    chk("ack", ack_q, 8'hfa);
    rd(8'h04, 8'hfa);
    rd(8'h07, 8'h10);
    rd(8'h06, 8'h00);
    for (k = 0; k < 12; k = k + 1)
    begin
      rd(8'h08 + 8'h02 * k, 8'h10 + k);
      rd(8'h09 + 8'h02 * k, ~(8'h10 + k));
    end
    $display("test window done");
    ob = {8'hfb, 8'h02, 16'h0020, 32'h1a2b_3c4d, 64'h0};
    cmd(ob);
    chk("nwr", n_wr[7:0], 8'h02);
    chk("wa", wa[7:0], 8'h21);
    chk("wd", wd[15:8], 8'h3c);
    chk("ack", ack_q, 8'hfb);
    cmd(ob);
    chk("nwr", n_wr[7:0], 8'h02);
    cmd({8'hfc, 120'h0});
    rd(8'h03, 8'h00);
    cmd({8'hfb, 8'h06, 16'h0030, 80'h0, 16'h6e7f});
    chk("nwr", n_wr[7:0], 8'h08);
    chk("wa", wa[7:0], 8'h35);
    chk("wd", wd[7:0], 8'h7f);
    cmd(0);
    cmd({8'hfb, 8'h07, 112'h0});
    chk("ack", ack_q, 8'hf0);
    chk("cerr", cerr_q, 8'h01);
    cmd({8'h05, 120'h0});
    chk("cerr", cerr_q, 8'h07);
    rd(8'h05, 8'h07);
    cmd({8'h06, 120'h0});
    chk("ack", ack_q, 8'h06);
    chk("cerr", cerr_q, 8'h00);
    chk("cmd", ext_cmd_q, 8'h06);
    $display("test commands done");
    bus_type_cfg = 2'h1;
    repeat (4) @(negedge clk);
    chk("nrs", n_rs[7:0], 8'h01);
    rd(8'h03, 8'h01);
    rd(8'h30, 8'h31);
    rd(8'hd0, 8'h00);
    blk_count_cfg = 4'hf;
    rd(8'hd0, 8'hbc);
    rd(8'he0, 8'h00);
    blk_count_cfg = 4'h0;
    rd(8'h30, 8'h00);
    $display("test blocks done");
    wrap_up;
  end
endmodule // tb_fieldbus_process_image
